// ---- tse_expander.v ----
/*
 * tray/tilt serial expander: link shift registers, mute routing, axi4-lite slave.
 * assumes link and status pins asynchronous to aclk and far slower than it.
 */
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`include "tse_regs.vh"
module tse_expander #(
	parameter DW = 16
) (
	// clock, reset, clock enable
	input  wire          aclk,
	input  wire          aresetn,
	input  wire          ce,
	// serial link from the user processor
	input  wire          ser_clk,
	input  wire          ser_enable,
	input  wire          ser_din,
	output reg           ser_dout,
	// status pins
	input  wire          tilt_below_neg,
	input  wire          tilt_above_pos,
	input  wire          hold_down_sw,
	input  wire          diff_sw,
	// parallel control outputs
	output reg           motor_dir,
	output reg           motor_drive,
	output reg           tilt_led_enable,
	output reg           mute_left,
	output reg           mute_right,
	output reg           audio_soft_mute,
	// audio path, same clock
	input  wire          aud_valid,
	input  wire [DW-1:0] aud_l_in,
	input  wire [DW-1:0] aud_r_in,
	output reg           aud_out_valid,
	output reg  [DW-1:0] aud_l_out,
	output reg  [DW-1:0] aud_r_out,
	// axi4-lite slave
	input  wire [3:0]    s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [3:0]    s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready
);
	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	reg  [6:0]           sync1_ff;      // first stage, read by stage two only
	reg  [6:0]           sync2_ff;      // second stage, safe to use
	reg                  clk_dly_ff;    // previous synced serial clock
	wire [6:0]           pins_in;
	wire                 s_clk;
	wire                 s_en;
	wire                 s_din;
	wire [3:0]           s_status;
	assign pins_in  = {ser_clk, ser_enable, ser_din, tilt_below_neg,
	                   tilt_above_pos, hold_down_sw, diff_sw};
	assign s_clk    = sync2_ff[6];
	assign s_en     = sync2_ff[5];
	assign s_din    = sync2_ff[4];
	assign s_status = sync2_ff[3:0];  // bit order fixed in header
	// two flops on every pin; the edge detector looks at stage two only
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_ff   <= 7'h00;
			sync2_ff   <= 7'h00;
			clk_dly_ff <= 1'b0;
		end
		else if (ce)
		begin
			sync1_ff   <= pins_in;
			sync2_ff   <= sync1_ff;
			clk_dly_ff <= s_clk;
		end
	end

	// ------------------------------------------------------------------
	// control registers, shift registers and output latch
	// ------------------------------------------------------------------
	reg  [1:0]           ctrl_ff;       // link enable, forced soft mute
	reg  [31:0]          xfers_ff;      // count of enable pulses seen
	reg                  en_dly_ff;     // previous synced enable
	wire                 link_on;
	wire                 sclk_rise;
	reg  [`TSE_OUT_W-1:0] out_sr_ff;    // bits shifted in from the master
	reg  [`TSE_OUT_W-1:0] out_lat_ff;   // parallel control outputs
	reg  [`TSE_IN_W-1:0]  in_sr_ff;     // status bits shifting out
	assign link_on   = ctrl_ff[`TSE_CTRL_LINK_EN];
	// one shared shift clock from the master moves both registers
	assign sclk_rise = s_clk & ~clk_dly_ff & link_on;
	// enable is a level, like a parallel-load pin: latch follows while high
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			out_sr_ff  <= `TSE_OUT_RESET;
			out_lat_ff <= `TSE_OUT_RESET;
			in_sr_ff   <= {`TSE_IN_W{1'b0}};
		end
		else if (ce)
		begin
			if (s_en && link_on)
			begin
				// capture inputs, transfer shifted word to outputs
				in_sr_ff   <= s_status;
				out_lat_ff <= out_sr_ff;
			end
			else if (sclk_rise)
			begin
				// separate line each way, msb first; latch untouched
				out_sr_ff <= {out_sr_ff[`TSE_OUT_W-2:0], s_din};
				in_sr_ff  <= {in_sr_ff[`TSE_IN_W-2:0], 1'b0};
			end
		end
	end
	// drive the serial return line and the parallel outputs from flops
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ser_dout        <= 1'b0;
			motor_dir       <= 1'b0;
			motor_drive     <= 1'b0;
			tilt_led_enable <= 1'b0;
			mute_left       <= 1'b0;
			mute_right      <= 1'b0;
			audio_soft_mute <= 1'b0;
		end
		else if (ce)
		begin
			ser_dout        <= in_sr_ff[`TSE_IN_W-1];
			motor_dir       <= out_lat_ff[`TSE_OUT_MOTOR_DIR];
			motor_drive     <= out_lat_ff[`TSE_OUT_MOTOR_DRV];
			tilt_led_enable <= out_lat_ff[`TSE_OUT_LED_EN];
			mute_left       <= out_lat_ff[`TSE_OUT_MUTE_L];
			mute_right      <= out_lat_ff[`TSE_OUT_MUTE_R];
			// software can force soft mute on top of the link's bit
			audio_soft_mute <= out_lat_ff[`TSE_OUT_SOFT_MUTE] |
			                   ctrl_ff[`TSE_CTRL_FORCE_SM];
		end
	end

	// ------------------------------------------------------------------
	// audio mute and routing
	// ------------------------------------------------------------------
	reg  [4:0]           att_ff;        // soft-mute attenuation, shift count
	wire signed [DW-1:0] l_src;
	wire signed [DW-1:0] r_src;
	// a muted channel is replaced by the other one; both muted gives zero
	assign l_src = mute_left ? (mute_right ? {DW{1'b0}} : aud_r_in) : aud_l_in;
	assign r_src = mute_right ? (mute_left ? {DW{1'b0}} : aud_l_in) : aud_r_in;
	// soft mute steps 6 db per sample (no click); one shared shift fades both
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			att_ff        <= 5'h00;
			aud_out_valid <= 1'b0;
			aud_l_out     <= {DW{1'b0}};
			aud_r_out     <= {DW{1'b0}};
		end
		else if (ce)
		begin
			aud_out_valid <= aud_valid;
			if (aud_valid)
			begin
				if (audio_soft_mute && att_ff != 5'h10)
					att_ff <= att_ff + 5'h01;
				else if (!audio_soft_mute && att_ff != 5'h00)
					att_ff <= att_ff - 5'h01;
				aud_l_out <= l_src >>> att_ff;
				aud_r_out <= r_src >>> att_ff;
			end
		end
	end

	// ------------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------------
	reg                  aw_have_ff;    // address held, waiting for data
	reg                  w_have_ff;     // data held, waiting for address
	reg  [3:0]           waddr_ff;
	reg  [31:0]          wdata_ff;
	reg  [3:0]           wstrb_ff;
	reg                  nxt_aw_have;
	reg                  nxt_w_have;
	reg                  nxt_bvalid;
	reg                  do_wr;
	reg  [3:0]           wa;
	reg  [31:0]          wd;
	reg  [3:0]           ws;
	// either order: a half that arrives first waits for the other
	always @*
	begin
		nxt_aw_have = aw_have_ff | (s_axi_awvalid & s_axi_awready);
		nxt_w_have  = w_have_ff | (s_axi_wvalid & s_axi_wready);
		wa          = aw_have_ff ? waddr_ff : s_axi_awaddr;
		wd          = w_have_ff ? wdata_ff : s_axi_wdata;
		ws          = w_have_ff ? wstrb_ff : s_axi_wstrb;
		do_wr       = nxt_aw_have & nxt_w_have & ~s_axi_bvalid;
		nxt_bvalid  = do_wr | (s_axi_bvalid & ~s_axi_bready);
		if (do_wr)
		begin
			nxt_aw_have = 1'b0;
			nxt_w_have  = 1'b0;
		end
	end
	// register writes; enable edges bump the transfer counter
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_ff    <= 1'b0;
			w_have_ff     <= 1'b0;
			waddr_ff      <= 4'h0;
			wdata_ff      <= 32'h0000_0000;
			wstrb_ff      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `TSE_RESP_OKAY;
			ctrl_ff       <= `TSE_CTRL_RESET;
			xfers_ff      <= 32'h0000_0000;
			en_dly_ff     <= 1'b0;
		end
		else if (ce)
		begin
			aw_have_ff    <= nxt_aw_have;
			w_have_ff     <= nxt_w_have;
			s_axi_awready <= ~nxt_aw_have & ~nxt_bvalid;
			s_axi_wready  <= ~nxt_w_have & ~nxt_bvalid;
			s_axi_bvalid  <= nxt_bvalid;
			en_dly_ff     <= s_en;
			if (s_axi_awvalid && s_axi_awready)
				waddr_ff <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			// clearing write loses no edge: one in the same cycle counts as 1
			if (do_wr && wa == `TSE_OFS_XFERS && ws[0])
				xfers_ff <= {31'h0000_0000, s_en & ~en_dly_ff & link_on};
			else if (s_en && !en_dly_ff && link_on)
				xfers_ff <= xfers_ff + 32'h0000_0001;
			if (do_wr && wa == `TSE_OFS_CTRL && ws[0])
				ctrl_ff <= wd[1:0];
			if (do_wr)
			begin
				case (wa)
				`TSE_OFS_CTRL, `TSE_OFS_STATUS, `TSE_OFS_XFERS:
					s_axi_bresp <= `TSE_RESP_OKAY;
				default:
					s_axi_bresp <= `TSE_RESP_SLVERR;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------------
	reg  [31:0]          rd_word;
	reg  [1:0]           rd_resp;
	// read decode; unmapped addresses answer zero with slverr
	always @*
	begin
		rd_word = 32'h0000_0000;
		rd_resp = `TSE_RESP_OKAY;
		case (s_axi_araddr)
		`TSE_OFS_CTRL:
			rd_word[1:0] = ctrl_ff;
		`TSE_OFS_STATUS:
		begin
			rd_word[`TSE_ST_OUT_LSB +: `TSE_OUT_W] = out_lat_ff;
			rd_word[`TSE_ST_IN_LSB +: `TSE_IN_W]   = s_status;
			rd_word[`TSE_ST_ENABLE]                = s_en;
		end
		`TSE_OFS_XFERS:
			rd_word = xfers_ff;
		default:
			rd_resp = `TSE_RESP_SLVERR;
		endcase
	end
	// one read at a time; arready drops while the answer stands
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `TSE_RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_resp;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			else if (!s_axi_rvalid)
				s_axi_arready <= 1'b1;
		end
	end
endmodule // tse_expander

// ---- tse_regs.vh ----
/*
 * register offsets, field positions and reset values of the tray/tilt
 * serial expander.
 * assumes an axi4-lite bus with 32-bit data, one register per aligned word.
 */
`ifndef TSE_REGS_VH
`define TSE_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define TSE_OFS_CTRL      4'h0
`define TSE_OFS_STATUS    4'h4
`define TSE_OFS_XFERS     4'h8

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define TSE_CTRL_LINK_EN  0
`define TSE_CTRL_FORCE_SM 1
`define TSE_CTRL_RESET    2'h1

// ----------------------------------------------------------------------
// parallel output bits of the output register (msb shifted in first)
// ----------------------------------------------------------------------
`define TSE_OUT_MOTOR_DIR 5
`define TSE_OUT_MOTOR_DRV 4
`define TSE_OUT_LED_EN    3
`define TSE_OUT_MUTE_L    2
`define TSE_OUT_MUTE_R    1
`define TSE_OUT_SOFT_MUTE 0
`define TSE_OUT_W         6
`define TSE_OUT_RESET     6'h00

// ----------------------------------------------------------------------
// status input bits of the input register (msb shifted out first)
// ----------------------------------------------------------------------
`define TSE_IN_TILT_NEG   3
`define TSE_IN_TILT_POS   2
`define TSE_IN_HOLD_DOWN  1
`define TSE_IN_DIFF_SW    0
`define TSE_IN_W          4

// ----------------------------------------------------------------------
// status register field positions
// ----------------------------------------------------------------------
`define TSE_ST_OUT_LSB    0
`define TSE_ST_IN_LSB     8
`define TSE_ST_ENABLE     12

// tilt comparator threshold magnitude, millivolts (analog, for reference)
`define TSE_TILT_THRESH_MV 150

// axi response codes
`define TSE_RESP_OKAY     2'h0
`define TSE_RESP_SLVERR   2'h2

`endif

// ---- tse_expander_asserts.sv ----
/* checker for tse_expander: link hold, status capture and audio mute rules.
   assumes one aclk domain and ce held high. */
`timescale 1ns/100ps
module tse_expander_asserts #(parameter DW = 16) (
	// clock and reset
	input wire          aclk,
	input wire          aresetn,
	// serial link and the status pin shifted out first
	input wire          ser_clk,
	input wire          ser_enable,
	input wire          ser_dout,
	input wire          tilt_below_neg,
	// write answer: a register write may move soft mute
	input wire          s_axi_bvalid,
	// parallel outputs
	input wire          motor_dir,
	input wire          motor_drive,
	input wire          tilt_led_enable,
	input wire          mute_left,
	input wire          mute_right,
	input wire          audio_soft_mute,
	// audio path
	input wire          aud_valid,
	input wire          aud_out_valid,
	input wire [DW-1:0] aud_l_out,
	input wire [DW-1:0] aud_r_out
);
	wire [5:0] outs = {motor_dir, motor_drive, tilt_led_enable, mute_left, mute_right,
		audio_soft_mute};
	reg  [4:0] sm_cnt_ff; // samples seen under soft mute, saturating
	// count samples; past 17 the attenuation must have reached its floor
	always @(posedge aclk)
	begin
		if (!aresetn || !audio_soft_mute)
			sm_cnt_ff <= 5'h00;
		else if (aud_valid && sm_cnt_ff != 5'h1f)
			sm_cnt_ff <= sm_cnt_ff + 5'h01;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// forced soft mute from software lands one edge after its write is answered
	property p_hold; (!ser_enable && !s_axi_bvalid)[*8] |-> $stable(outs); endproperty
	a_hold: assert property (p_hold) else $error("outputs moved with enable low");
	property p_first; (ser_enable && $stable(tilt_below_neg))[*8] |-> ser_dout == tilt_below_neg;
	endproperty
	a_first: assert property (p_first) else $error("captured status not on dout");
	property p_quiet; (!ser_enable && !ser_clk)[*8] |-> $stable(ser_dout); endproperty
	a_quiet: assert property (p_quiet) else $error("dout moved without clock");
	property p_rt_l; aud_valid && mute_left && !mute_right ##1 mute_left && !mute_right
		|-> aud_out_valid && aud_l_out == aud_r_out; endproperty
	a_rt_l: assert property (p_rt_l) else $error("left mute not fed from right");
	property p_rt_r; aud_valid && mute_right && !mute_left ##1 mute_right && !mute_left
		|-> aud_out_valid && aud_r_out == aud_l_out; endproperty
	a_rt_r: assert property (p_rt_r) else $error("right mute not fed from left");
	property p_both; aud_valid && mute_left && mute_right ##1 mute_left && mute_right
		|-> aud_l_out == 0 && aud_r_out == 0; endproperty
	a_both: assert property (p_both) else $error("both muted yet audio out");
	property p_floor; sm_cnt_ff >= 5'd18 && aud_out_valid
		|-> (aud_l_out == 0 || aud_l_out == {DW{1'b1}}) && (aud_r_out == 0 || aud_r_out == {DW{1'b1}});
	endproperty
	a_floor: assert property (p_floor) else $error("soft mute did not silence");
	property p_aud; aud_valid |=> aud_out_valid; endproperty
	a_aud: assert property (p_aud) else $error("audio sample lost");
	c_rt: cover property (aud_valid && mute_left && !mute_right);
	c_floor: cover property (sm_cnt_ff >= 5'd18 && aud_out_valid);
	c_load: cover property (ser_enable[*8]);
endmodule // tse_expander_asserts
bind tse_expander tse_expander_asserts #(.DW(DW)) tse_expander_asserts_i (.aclk(aclk),
	.aresetn(aresetn), .ser_clk(ser_clk), .ser_enable(ser_enable), .ser_dout(ser_dout),
	.tilt_below_neg(tilt_below_neg), .s_axi_bvalid(s_axi_bvalid),
	.motor_dir(motor_dir), .motor_drive(motor_drive),
	.tilt_led_enable(tilt_led_enable), .mute_left(mute_left), .mute_right(mute_right),
	.audio_soft_mute(audio_soft_mute), .aud_valid(aud_valid), .aud_out_valid(aud_out_valid),
	.aud_l_out(aud_l_out), .aud_r_out(aud_r_out));

// ---- tse_link_master.sv ----
/* behavioural user processor: serial master of the expander link.
   assumes nothing of aclk; a 125 ns shift clock, still between frames. */
`timescale 1ns/100ps
module tse_link_master (
	// serial pins
	output reg  ser_clk,
	output reg  ser_enable,
	output reg  ser_din,
	input  wire ser_dout
);
	reg busy; // capture pulse and shifts under way
	initial
	begin
		ser_clk = 1'b0;
		ser_enable = 1'b0;
		ser_din = 1'b0;
		busy = 1'b0;
	end
	// outside frames the data line carries no meaning, so it keeps changing
	always #4 if (!busy) ser_din = ~ser_din;
	// capture pulse, six shifts msb first, then optional transfer pulse
	task frame(input [5:0] w, input xfer, output [3:0] st);
		integer b;
	begin
		busy = 1'b1;
		ser_enable = 1'b1;
		#125 ser_enable = 1'b0;
		for (b = 5; b >= 0; b = b - 1)
		begin
			ser_din = w[b]; // own line per direction
			#62.5;
			if (b > 1) st[b-2] = ser_dout;
			ser_clk = 1'b1; // one shared shift clock
			#62.5 ser_clk = 1'b0;
		end
		busy = 1'b0;
		ser_enable = xfer;
		#125 ser_enable = 1'b0;
		#125;
	end
	endtask
endmodule // tse_link_master

// ---- test_tray_tilt_serial_expander.sv ----
/* self-checking bench for tse_expander: link frames, registers, audio.
   assumes tse_regs.vh on the include path. */
`timescale 1ns/100ps
`include "tse_regs.vh"
module test_tray_tilt_serial_expander;
	reg          aclk, aresetn, aud_valid, awvalid, wvalid, bready, arvalid, rready;
	reg  [3:0]   pins, awaddr, araddr;
	reg  [15:0]  aud_l, aud_r, el;
	reg  [31:0]  wdata, rd;
	reg  [1:0]   rs;
	reg  [5:0]   w, expo;
	reg  [3:0]   st;
	wire         awready, wready, bvalid, arready, rvalid, aov;
	wire         ser_clk, ser_enable, ser_din, ser_dout;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [5:0]   outs;
	wire [15:0]  lo, ro;
	integer      n_fail, n_tests, seed, i, r;
	tse_expander #(.DW(16)) tse_expander_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.ser_clk(ser_clk), .ser_enable(ser_enable), .ser_din(ser_din), .ser_dout(ser_dout),
		.tilt_below_neg(pins[3]), .tilt_above_pos(pins[2]), .hold_down_sw(pins[1]),
		.diff_sw(pins[0]), .motor_dir(outs[5]), .motor_drive(outs[4]),
		.tilt_led_enable(outs[3]), .mute_left(outs[2]), .mute_right(outs[1]),
		.audio_soft_mute(outs[0]), .aud_valid(aud_valid), .aud_l_in(aud_l), .aud_r_in(aud_r),
		.aud_out_valid(aov), .aud_l_out(lo), .aud_r_out(ro), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	tse_link_master tse_link_master_i (.ser_clk(ser_clk), .ser_enable(ser_enable),
		.ser_din(ser_din), .ser_dout(ser_dout));
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task chk(input string nm, input [31:0] ex, input [31:0] got);
	begin
		n_tests = n_tests + 1;
		if (got !== ex)
		begin
			n_fail = n_fail + 1;
			$display("mismatch %0s expected %h seen %h", nm, ex, got);
		end
	end
	endtask
	// axi write: both halves offered together, each dropped once taken
	task axw(input [3:0] a, input [31:0] d);
	begin
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	end
	endtask
	task axr(input [3:0] a);
	begin
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	end
	endtask
	// one audio sample, outputs read once the taking edge has settled
	task snd;
	begin
		@(posedge aclk);
		aud_valid <= 1'b1;
		r = $random(seed);
		aud_l <= r[15:0];
		aud_r <= r[31:16];
		@(posedge aclk);
		aud_valid <= 1'b0;
		#1;
	end
	endtask
	task tally_and_finish;
	begin
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		#100000;
		n_fail = n_fail + 1;
		tally_and_finish;
	end
	initial
	begin
		n_fail = 0;
		n_tests = 0;
		seed = 32'h78ea4ff4;
		{aresetn, aud_valid, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{pins, awaddr, araddr, aud_l, aud_r, wdata} = 76'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		axr(`TSE_OFS_CTRL);
		chk("ctrl", `TSE_CTRL_RESET, rd);
		chk("outputs", `TSE_OUT_RESET, outs);
		axr(4'hc);
		chk("unmapped read", 32'h2, {rd[29:0], rs});
		axw(4'hc, 32'h1);
		chk("unmapped write", `TSE_RESP_SLVERR, rs);
		$display("reset and register checks done");
		axw(`TSE_OFS_XFERS, 32'h0);
		expo = 6'h00;
		for (i = 0; i < 8; i = i + 1)
		begin
			r = $random(seed);
			w = r[5:0];
			w[4] = (i == 3); // motor driven rarely
			pins <= r[11:8];
			@(posedge aclk);
			tse_link_master_i.frame(w, i != 5, st);
			if (i != 5) expo = w;
			chk("status", pins, st);
			chk("outputs", expo, outs);
		end
		axr(`TSE_OFS_STATUS);
		chk("status reg", {20'h0, pins, 2'b00, expo}, rd);
		axr(`TSE_OFS_XFERS);
		chk("xfers", 32'd15, rd);
		$display("link frames done");
		for (i = 0; i < 4; i = i + 1)
		begin
			tse_link_master_i.frame({3'b001, i[1:0], 1'b0}, 1'b1, st);
			snd;
			el = i[1] ? (i[0] ? 16'h0 : aud_r) : aud_l;
			chk("left out", el, lo);
			el = i[0] ? (i[1] ? 16'h0 : aud_l) : aud_r;
			chk("right out", el, ro);
		end
		tse_link_master_i.frame(6'h00, 1'b1, st);
		$display("mute routing done");
		axw(`TSE_OFS_CTRL, 32'h3);
		repeat (20) snd;
		chk("soft flag", 1'b1, outs[0]);
		chk("soft left", {16{aud_l[15]}}, lo);
		chk("soft right", {16{aud_r[15]}}, ro);
		axw(`TSE_OFS_CTRL, 32'h1);
		repeat (20) snd;
		chk("released left", aud_l, lo);
		$display("soft mute done");
		tally_and_finish;
	end
endmodule // test_tray_tilt_serial_expander
